// [operand_field_decode_defs.vh]
// constants for the operand field decode stage
`ifndef OPERAND_FIELD_DECODE_DEFS_VH
`define OPERAND_FIELD_DECODE_DEFS_VH

// operand interpretation mode codes
`define OFD_MODE_W        4
`define OFD_MODE_DIRECT   4'h0
`define OFD_MODE_EXTENDED 4'h1
`define OFD_MODE_IMM8     4'h2
`define OFD_MODE_IMM16    4'h3
`define OFD_MODE_BITMASK  4'h4
`define OFD_MODE_REL8     4'h5
`define OFD_MODE_REL16    4'h6
`define OFD_MODE_LOOP9    4'h7
`define OFD_MODE_TRAP     4'h8
`define OFD_MODE_CALL     4'h9
`define OFD_MODE_IDX5     4'hA
`define OFD_MODE_IDX9     4'hB
`define OFD_MODE_IDX16    4'hC
`define OFD_MODE_IDXACC   4'hD
`define OFD_MODE_IDXAUTO  4'hE

// index base register select
`define OFD_BASE_X  2'h0
`define OFD_BASE_Y  2'h1
`define OFD_BASE_SP 2'h2
`define OFD_BASE_PC 2'h3

// accumulator offset select
`define OFD_ACC_A 2'h0
`define OFD_ACC_B 2'h1
`define OFD_ACC_D 2'h2

// valid trap number ranges
`define OFD_TRAP_LO1 8'h30
`define OFD_TRAP_HI1 8'h39
`define OFD_TRAP_LO2 8'h40

// reset values
`define OFD_RST_WORD 16'h0000
`define OFD_RST_BYTE 8'h00

// memory expansion page width accepted by the core
`define OFD_PAGE_BITS 8

`endif

// [ofd_wrap_adder.v]
// 16-bit address adder that wraps modulo 65536
`timescale 1ns/100ps

module ofd_wrap_adder (
	input  wire [15:0] BASE_IN,
	input  wire [15:0] OFFSET_IN,
	output wire [15:0] SUM_OUT
);

	wire [16:0] full_sum;

	// carry out is discarded: no overflow indication
	assign full_sum = {1'b0, BASE_IN} + {1'b0, OFFSET_IN};
	assign SUM_OUT  = full_sum[15:0];

endmodule // ofd_wrap_adder

// [operand_field_decode.v]
// operand field decode stage: addresses, immediates, masks, offsets, traps, pages
`timescale 1ns/100ps
`include "operand_field_decode_defs.vh"

module operand_field_decode #(
	parameter PAGE_BITS = `OFD_PAGE_BITS
) (
	input  wire        CORE_CLK_IN,
	input  wire        SRST_IN,
	input  wire        OP_VALID_IN,
	input  wire [3:0]  MODE_IN,
	input  wire [7:0]  BYTE0_IN,
	input  wire [7:0]  BYTE1_IN,
	input  wire [7:0]  BYTE2_IN,
	input  wire        SIGN_BIT_IN,
	input  wire [4:0]  OFFSET5_IN,
	input  wire [1:0]  BASE_SEL_IN,
	input  wire [1:0]  ACC_SEL_IN,
	input  wire [2:0]  AUTO_STEP_IN,
	input  wire        AUTO_DEC_IN,
	input  wire        AUTO_PRE_IN,
	input  wire        BIT_SET_IN,
	input  wire [7:0]  OPERAND_IN,
	input  wire [15:0] NEXT_PC_IN,
	input  wire [15:0] INDEX_X_IN,
	input  wire [15:0] INDEX_Y_IN,
	input  wire [15:0] STACK_PTR_IN,
	input  wire [7:0]  ACC_A_IN,
	input  wire [7:0]  ACC_B_IN,
	output wire [15:0] EFF_ADDR_OUT,
	output wire [15:0] DATA_OUT,
	output wire [15:0] TARGET_OUT,
	output wire [15:0] INDEX_WB_OUT,
	output wire [1:0]  INDEX_WB_SEL_OUT,
	output wire        INDEX_WB_EN_OUT,
	output wire [7:0]  TRAP_NUM_OUT,
	output wire [7:0]  PAGE_OUT,
	output wire        DONE_OUT,
	output wire        FAULT_OUT
);

	// sign-extend a 9-bit offset given as sign bit and low byte
	function [15:0] sext9;
		input       sign;
		input [7:0] low;
		begin
			sext9 = {{8{sign}}, low};
		end
	endfunction

	// sign-extend a 5-bit offset
	function [15:0] sext5;
		input [4:0] off;
		begin
			sext5 = {{11{off[4]}}, off};
		end
	endfunction

	// join a high-order byte and a low-order byte
	function [15:0] join16;
		input [7:0] hi;
		input [7:0] lo;
		begin
			join16 = {hi, lo};
		end
	endfunction

	// trap number range check
	function trap_ok;
		input [7:0] num;
		begin
			trap_ok = ((num >= `OFD_TRAP_LO1) && (num <= `OFD_TRAP_HI1)) ||
				(num >= `OFD_TRAP_LO2);
		end
	endfunction

	localparam [7:0] PAGE_MASK = 8'hFF >> (8 - PAGE_BITS);

	reg  [15:0] eff_addr_reg;
	reg  [15:0] eff_addr_next;
	reg  [15:0] data_reg;
	reg  [15:0] data_next;
	reg  [15:0] target_reg;
	reg  [15:0] target_next;
	reg  [15:0] index_wb_reg;
	reg  [15:0] index_wb_next;
	reg  [1:0]  index_wb_sel_reg;
	reg  [1:0]  index_wb_sel_next;
	reg         index_wb_en_reg;
	reg         index_wb_en_next;
	reg  [7:0]  trap_num_reg;
	reg  [7:0]  trap_num_next;
	reg  [7:0]  page_reg;
	reg  [7:0]  page_next;
	reg         done_reg;
	reg         fault_reg;
	reg         fault_next;

	reg  [15:0] base_value;
	reg  [15:0] acc_value;
	reg  [15:0] add_base;
	reg  [15:0] add_offset;
	reg  [15:0] auto_step;
	wire [15:0] add_sum;

	// base register select; PC reads as address after the instruction
	always @* begin
		case (BASE_SEL_IN)
			`OFD_BASE_X:  base_value = INDEX_X_IN;
			`OFD_BASE_Y:  base_value = INDEX_Y_IN;
			`OFD_BASE_SP: base_value = STACK_PTR_IN;
			default:      base_value = NEXT_PC_IN;
		endcase
	end

	// accumulator offset select, A and B taken as unsigned
	always @* begin
		case (ACC_SEL_IN)
			`OFD_ACC_A: acc_value = {8'h00, ACC_A_IN};
			`OFD_ACC_B: acc_value = {8'h00, ACC_B_IN};
			default:    acc_value = join16(ACC_A_IN, ACC_B_IN);
		endcase
	end

	// step of 1..8 coded as 0..7, negated for decrement
	always @* begin
		auto_step = {13'h0000, AUTO_STEP_IN} + 16'h0001;
		if (AUTO_DEC_IN) begin
			auto_step = (~auto_step) + 16'h0001;
		end
	end

	// operand pair for the one shared address adder
	always @* begin
		add_base   = base_value;
		add_offset = 16'h0000;
		case (MODE_IN)
			`OFD_MODE_REL8: begin
				add_base   = NEXT_PC_IN;
				add_offset = sext9(BYTE0_IN[7], BYTE0_IN);
			end
			`OFD_MODE_REL16: begin
				add_base   = NEXT_PC_IN;
				add_offset = join16(BYTE0_IN, BYTE1_IN);
			end
			`OFD_MODE_LOOP9: begin
				add_base   = NEXT_PC_IN;
				add_offset = sext9(SIGN_BIT_IN, BYTE0_IN);
			end
			`OFD_MODE_IDX5: begin
				add_offset = sext5(OFFSET5_IN);
			end
			`OFD_MODE_IDX9: begin
				add_offset = sext9(SIGN_BIT_IN, BYTE0_IN);
			end
			`OFD_MODE_IDX16: begin
				// same result whether read as signed or unsigned
				add_offset = join16(BYTE0_IN, BYTE1_IN);
			end
			`OFD_MODE_IDXACC: begin
				add_offset = acc_value;
			end
			`OFD_MODE_IDXAUTO: begin
				add_offset = auto_step;
			end
			default: begin
				add_offset = 16'h0000;
			end
		endcase
	end

	ofd_wrap_adder u_adder (
		.BASE_IN   (add_base),
		.OFFSET_IN (add_offset),
		.SUM_OUT   (add_sum)
	);

	// decode of the operand bytes per mode; payloads hold when not decoding
	always @* begin
		eff_addr_next     = eff_addr_reg;
		data_next         = data_reg;
		target_next       = target_reg;
		index_wb_next     = index_wb_reg;
		index_wb_sel_next = index_wb_sel_reg;
		index_wb_en_next  = 1'b0;
		trap_num_next     = trap_num_reg;
		page_next         = page_reg;
		fault_next        = 1'b0;
		if (OP_VALID_IN) begin
			case (MODE_IN)
				`OFD_MODE_DIRECT: begin
					eff_addr_next = join16(8'h00, BYTE0_IN);
				end
				`OFD_MODE_EXTENDED: begin
					eff_addr_next = join16(BYTE0_IN, BYTE1_IN);
				end
				`OFD_MODE_IMM8: begin
					data_next = join16(8'h00, BYTE0_IN);
				end
				`OFD_MODE_IMM16: begin
					data_next = join16(BYTE0_IN, BYTE1_IN);
				end
				`OFD_MODE_BITMASK: begin
					if (BIT_SET_IN) begin
						data_next = join16(8'h00, OPERAND_IN | BYTE0_IN);
					end else begin
						data_next = join16(8'h00, OPERAND_IN & ~BYTE0_IN);
					end
				end
				`OFD_MODE_REL8, `OFD_MODE_REL16, `OFD_MODE_LOOP9: begin
					target_next = add_sum;
				end
				`OFD_MODE_TRAP: begin
					trap_num_next = BYTE0_IN;
					fault_next    = ~trap_ok(BYTE0_IN);
				end
				`OFD_MODE_CALL: begin
					eff_addr_next = join16(BYTE0_IN, BYTE1_IN);
					page_next     = BYTE2_IN & PAGE_MASK;
				end
				`OFD_MODE_IDX5, `OFD_MODE_IDX9, `OFD_MODE_IDX16: begin
					eff_addr_next = add_sum;
				end
				`OFD_MODE_IDXACC: begin
					if (ACC_SEL_IN == 2'h3) begin
						fault_next = 1'b1;
					end else begin
						eff_addr_next = add_sum;
					end
				end
				`OFD_MODE_IDXAUTO: begin
					// the program counter cannot be auto-stepped
					if (BASE_SEL_IN == `OFD_BASE_PC) begin
						fault_next = 1'b1;
					end else begin
						index_wb_next     = add_sum;
						index_wb_sel_next = BASE_SEL_IN;
						index_wb_en_next  = 1'b1;
						eff_addr_next     = AUTO_PRE_IN ? add_sum : base_value;
					end
				end
				default: begin
					fault_next = 1'b1;
				end
			endcase
		end
	end

	always @(posedge CORE_CLK_IN) begin
		if (SRST_IN) begin
			eff_addr_reg     <= `OFD_RST_WORD;
			data_reg         <= `OFD_RST_WORD;
			target_reg       <= `OFD_RST_WORD;
			index_wb_reg     <= `OFD_RST_WORD;
			index_wb_sel_reg <= 2'h0;
			index_wb_en_reg  <= 1'b0;
			trap_num_reg     <= `OFD_RST_BYTE;
			page_reg         <= `OFD_RST_BYTE;
			done_reg         <= 1'b0;
			fault_reg        <= 1'b0;
		end else begin
			eff_addr_reg     <= eff_addr_next;
			data_reg         <= data_next;
			target_reg       <= target_next;
			index_wb_reg     <= index_wb_next;
			index_wb_sel_reg <= index_wb_sel_next;
			index_wb_en_reg  <= index_wb_en_next;
			trap_num_reg     <= trap_num_next;
			page_reg         <= page_next;
			done_reg         <= OP_VALID_IN;
			fault_reg        <= fault_next;
		end
	end

	assign EFF_ADDR_OUT     = eff_addr_reg;
	assign DATA_OUT         = data_reg;
	assign TARGET_OUT       = target_reg;
	assign INDEX_WB_OUT     = index_wb_reg;
	assign INDEX_WB_SEL_OUT = index_wb_sel_reg;
	assign INDEX_WB_EN_OUT  = index_wb_en_reg;
	assign TRAP_NUM_OUT     = trap_num_reg;
	assign PAGE_OUT         = page_reg;
	assign DONE_OUT         = done_reg;
	assign FAULT_OUT        = fault_reg;

endmodule // operand_field_decode

// [operand_field_decode_monitor.sv]
// assertions for the operand field decode stage
`timescale 1ns/100ps
module operand_field_decode_monitor (
	input wire        CORE_CLK_IN,
	input wire        SRST_IN,
	input wire        OP_VALID_IN,
	input wire [3:0]  MODE_IN,
	input wire [7:0]  BYTE0_IN,
	input wire [7:0]  BYTE1_IN,
	input wire        SIGN_BIT_IN,
	input wire [4:0]  OFFSET5_IN,
	input wire [1:0]  BASE_SEL_IN,
	input wire [15:0] NEXT_PC_IN,
	input wire [15:0] INDEX_X_IN,
	input wire [15:0] EFF_ADDR_OUT,
	input wire [15:0] DATA_OUT,
	input wire [15:0] TARGET_OUT,
	input wire        FAULT_OUT
);
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (SRST_IN);
	// idle cycles map onto the illegal code so no mode antecedent fires
	wire [3:0] m = OP_VALID_IN ? MODE_IN : 4'hF;
	reg  [7:0]  p0, p1;
	reg  [15:0] pc, px;
	reg  [4:0]  o;
	reg         sg;
	always @(posedge CORE_CLK_IN) begin
		p0 <= BYTE0_IN;
		p1 <= BYTE1_IN;
		pc <= NEXT_PC_IN;
		px <= INDEX_X_IN;
		o <= OFFSET5_IN;
		sg <= SIGN_BIT_IN;
	end
	direct_addr_a: assert property (m == 4'h0 |=> EFF_ADDR_OUT == {8'h00, p0})
		else $error("direct address");
	ext_addr_a: assert property (m == 4'h1 |=> EFF_ADDR_OUT == {p0, p1})
		else $error("extended address");
	imm_pair_a: assert property (m == 4'h3 |=> DATA_OUT == {p0, p1})
		else $error("immediate pair");
	imm_byte_a: assert property (m == 4'h2 |=> DATA_OUT == {8'h00, p0})
		else $error("immediate byte");
	short_branch_a: assert property (m == 4'h5 |=> TARGET_OUT == pc + {{8{p0[7]}}, p0})
		else $error("short branch");
	long_branch_a: assert property (m == 4'h6 |=> TARGET_OUT == pc + {p0, p1})
		else $error("long branch");
	loop_target_a: assert property (m == 4'h7 |=> TARGET_OUT == pc + {{7{sg}}, sg, p0})
		else $error("loop target");
	trap_range_a: assert property (m == 4'h8 |=> FAULT_OUT == !((p0 >= 8'h30 && p0 <= 8'h39) || p0 >= 8'h40))
		else $error("trap range");
	idx5_offset_a: assert property (m == 4'hA && BASE_SEL_IN == 2'h0 |=> EFF_ADDR_OUT == px + {{11{o[4]}}, o})
		else $error("short index offset");
	pc_base_a: assert property (m == 4'hB && BASE_SEL_IN == 2'h3 |=> EFF_ADDR_OUT == pc + {{7{sg}}, sg, p0})
		else $error("pc based index");
endmodule // operand_field_decode_monitor

bind operand_field_decode operand_field_decode_monitor operand_field_decode_monitor_inst (.*);

// [operand_field_decode_tb_top.sv]
// self-checking bench for the operand field decode stage
`timescale 1ns/100ps
module operand_field_decode_tb_top;
	reg         clk, rst, v, s, dec, pre, bs;
	reg  [3:0]  md;
	reg  [7:0]  b0, b1, b2, opd, a, b;
	reg  [4:0]  o5;
	reg  [1:0]  bsel, asel;
	reg  [2:0]  st;
	reg  [15:0] pc, x, y, sp;
	wire [15:0] ea, dat, tgt, wb;
	wire [1:0]  wsel;
	wire [7:0]  tn, pg;
	wire        wen, dn, flt;
	integer     n_errors = 0;
	integer     comparisons = 0;
	integer     i;
	localparam [55:0] TV = 56'h00_2F_30_39_3A_40_FF;

	operand_field_decode #(.PAGE_BITS(4)) operand_field_decode_inst (
		.CORE_CLK_IN(clk), .SRST_IN(rst), .OP_VALID_IN(v), .MODE_IN(md), .BYTE0_IN(b0), .BYTE1_IN(b1),
		.BYTE2_IN(b2), .SIGN_BIT_IN(s), .OFFSET5_IN(o5), .BASE_SEL_IN(bsel), .ACC_SEL_IN(asel),
		.AUTO_STEP_IN(st), .AUTO_DEC_IN(dec), .AUTO_PRE_IN(pre), .BIT_SET_IN(bs), .OPERAND_IN(opd),
		.NEXT_PC_IN(pc), .INDEX_X_IN(x), .INDEX_Y_IN(y), .STACK_PTR_IN(sp), .ACC_A_IN(a), .ACC_B_IN(b),
		.EFF_ADDR_OUT(ea), .DATA_OUT(dat), .TARGET_OUT(tgt), .INDEX_WB_OUT(wb), .INDEX_WB_SEL_OUT(wsel),
		.INDEX_WB_EN_OUT(wen), .TRAP_NUM_OUT(tn), .PAGE_OUT(pg), .DONE_OUT(dn), .FAULT_OUT(flt));

	always #2.5 clk = ~clk;

	task chk(input [23:0] got, input [23:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// one request, answer looked at just after the edge that takes it
	task go(input [3:0] m);
		md <= m;
		v <= 1'b1;
		@(posedge clk);
		v <= 1'b0;
		#1;
	endtask

	task t_addr;
		@(posedge clk) b0 <= 8'hFF;
		go(4'h0);
		chk(ea, 16'h00FF);
		@(posedge clk) {b0, b1} <= 16'h1234;
		go(4'h1);
		chk(ea, 16'h1234);
		@(posedge clk);
		go(4'h3);
		chk(dat, 16'h1234);
		@(posedge clk) b0 <= 8'hC3;
		go(4'h2);
		chk(dat, 16'h00C3);
		@(posedge clk) {b0, opd, bs, b2} <= 25'h1E0B5A7;
		go(4'h4);
		chk(dat, 16'h00FA);
		@(posedge clk) bs <= 1'b0;
		go(4'h4);
		chk(dat, 16'h000A);
		@(posedge clk);
		go(4'h9);
		chk({pg, dat}, 24'h07000A);
		chk(ea, 16'hF034);
		$display("t_addr done");
	endtask

	task t_branch;
		@(posedge clk) {b0, pc} <= 24'h801000;
		go(4'h5);
		chk(tgt, 16'h0F80);
		@(posedge clk) {b0, b1} <= 16'hF000;
		go(4'h6);
		chk(tgt, 16'h0000);
		@(posedge clk) {s, b0} <= 9'h100;
		go(4'h7);
		chk(tgt, 16'h0F00);
		$display("t_branch done");
	endtask

	task t_trap;
		for (i = 0; i < 7; i++) begin
			@(posedge clk) b0 <= TV[8*i +: 8];
			go(4'h8);
			chk({tn, dn, flt}, {TV[8*i +: 8], 1'b1, !((b0 >= 8'h30 && b0 <= 8'h39) || b0 >= 8'h40)});
		end
		$display("t_trap done");
	endtask

	// mid-run reset clears the outputs; a request follows the release after one idle edge
	task t_reset;
		@(posedge clk) rst <= 1'b1;
		@(posedge clk) rst <= 1'b0;
		#1;
		chk(ea, 16'h0000);
		chk(tgt, 16'h0000);
		chk({dn, flt, wen}, 3'b000);
		@(posedge clk) b0 <= 8'h5A;
		go(4'h0);
		chk(ea, 16'h005A);
		$display("t_reset done");
	endtask

	task t_index;
		@(posedge clk) {x, y, sp} <= 48'h2000_FFF0_0100;
		{a, b, o5} <= {8'h80, 8'h01, 5'h10};
		go(4'hA);
		chk(ea, 16'h1FF0);
		@(posedge clk) {s, b0, bsel} <= 11'h403;
		go(4'hB);
		chk(ea, 16'h0F00);
		@(posedge clk) {b0, b1, bsel} <= 18'h00081;
		go(4'hC);
		chk(ea, 16'h0010);
		@(posedge clk) {asel, bsel} <= 4'hA;
		go(4'hD);
		chk(ea, 16'h8101);
		@(posedge clk) asel <= 2'h3;
		go(4'hD);
		chk({flt, dn}, 2'b11);
		@(posedge clk) asel <= 2'h0;
		go(4'hD);
		chk(ea, 16'h0180);
		@(posedge clk) asel <= 2'h1;
		go(4'hD);
		chk(ea, 16'h0101);
		@(posedge clk);
		go(4'hF);
		chk({flt, dn}, 2'b11);
		@(posedge clk) {bsel, st, dec, pre} <= 7'h07;
		go(4'hE);
		chk({wen, wsel, ea}, 19'h41FFE);
		chk(wb, 16'h1FFE);
		@(posedge clk) {bsel, st, dec, pre} <= 7'h5C;
		go(4'hE);
		chk({wen, wsel, ea}, 19'h60100);
		chk(wb, 16'h0108);
		@(posedge clk) bsel <= 2'h3;
		go(4'hE);
		chk({flt, wen}, 2'b10);
		$display("t_index done");
	endtask

	task conclude;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		#5000;
		n_errors++;
		conclude;
	end

	initial begin
		{clk, v, s, dec, pre, bs, md, b0, b1, b2, opd, a, b, o5, bsel, asel, st, pc, x, y, sp} = 0;
		rst = 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_addr;
		t_branch;
		t_trap;
		t_reset;
		t_index;
		conclude;
	end
endmodule // operand_field_decode_tb_top
